// ==== hdl/flash_ctrl_unlock_interlock.sv ====
// host controller driving the flash control registers with unlock sequences and interlocks
`timescale 1ns/1ps
// What this block does
// - A guarded bit of the set group is set by writing zero to it and then one right after.
// - Nothing else reaches the device between the two writes of an unlock pair.
// - A block lock bit is cleared by writing one to it and then zero right after, with nothing between.
// - Stop or wait is never entered while an erase is suspended.
// - Stop or wait is never entered while the flash ready flag reads zero.
// - Stop or wait is never entered while low-current read is enabled.
// - A flash address already programmed is not programmed again before an erase.
// - Blank check is not issued while an erase is suspended.
// - Low-current read is enabled only with the cpu clock divided by 4, 8 or 16.
// - The divide ratio is set first and low-current read enabled only afterwards.
module flash_ctrl_unlock_interlock #(
  parameter int ADDR_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [1:0] dev_addr,
  output logic [7:0] dev_wdata,
  output logic dev_wr,
  output logic dev_rd,
  input wire logic [7:0] dev_rdata,
  output logic [2:0] cpu_div,
  output logic stop_req,
  output logic wait_req,
  output logic fcmd_valid,
  output logic [1:0] fcmd_op,
  output logic [ADDR_W-1:0] fcmd_addr
);
  flash_host_pkg::seq_state_type state_ff, nxt_state;
  logic ap_wr_ff, nxt_ap_wr;
  logic [7:0] ap_addr_ff, nxt_ap_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [1:0] dev_addr_ff, nxt_dev_addr;
  logic [7:0] dev_wdata_ff, nxt_dev_wdata;
  logic dev_wr_ff, nxt_dev_wr;
  logic dev_rd_ff, nxt_dev_rd;
  logic poll_sel_ff, nxt_poll_sel;
  logic [7:0] fin_ff, nxt_fin;
  logic [7:0] shadow_a_ff, nxt_shadow_a;
  logic [7:0] shadow_b_ff, nxt_shadow_b;
  logic [7:0] shadow_c_ff, nxt_shadow_c;
  logic ready_ff, nxt_ready;
  logic [2:0] clk_div_ff, nxt_clk_div;
  logic ref_bit_ff, nxt_ref_bit;
  logic ref_lp_ff, nxt_ref_lp;
  logic ref_cmd_ff, nxt_ref_cmd;
  logic stop_ff, nxt_stop;
  logic wait_ff, nxt_wait;
  logic fcmd_valid_ff, nxt_fcmd_valid;
  logic [1:0] fcmd_op_ff, nxt_fcmd_op;
  logic [ADDR_W-1:0] fcmd_addr_ff, nxt_fcmd_addr;
  logic trk_mark;
  logic trk_clear;
  logic trk_hit;

  // decoded fields of the write data
  logic [2:0] bc_idx;
  logic [1:0] bc_reg;
  logic bc_val;
  logic [1:0] fc_op;
  logic [ADDR_W-1:0] fc_addr;
  assign bc_idx = hwdata[flash_host_pkg::BC_IDX_LSB +: 3];
  assign bc_reg = hwdata[flash_host_pkg::BC_REG_LSB +: 2];
  assign bc_val = hwdata[flash_host_pkg::BC_VAL_BIT];
  assign fc_op = hwdata[flash_host_pkg::FC_OP_LSB +: 2];
  assign fc_addr = hwdata[flash_host_pkg::FC_ADDR_LSB +: ADDR_W];

  logic suspended;
  logic lcr_on;
  assign suspended = shadow_c_ff[flash_host_pkg::ERASE_SUSPEND_REQUEST_BIT];
  assign lcr_on = shadow_c_ff[flash_host_pkg::LOW_CURRENT_READ_ENABLE_BIT];

  prog_tracker #(
    .ADDR_W(ADDR_W)
  ) prog_tracker_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .chk_addr(fc_addr),
    .mark(trk_mark),
    .clear_all(trk_clear),
    .hit(trk_hit)
  );

  always_comb begin
    logic [31:0] rd_val;
    logic [7:0] cur;
    logic [7:0] bmask;
    logic [7:0] fin;
    logic [7:0] set_guard;
    logic [7:0] clr_guard;
    logic unlock;
    logic lcr_bad;
    rd_val = 32'h0000_0000;
    cur = 8'h00;
    bmask = 8'h00;
    fin = 8'h00;
    set_guard = 8'h00;
    clr_guard = 8'h00;
    unlock = 1'b0;
    lcr_bad = 1'b0;
    nxt_state = state_ff;
    nxt_ap_wr = 1'b0;
    nxt_ap_addr = ap_addr_ff;
    nxt_hrdata = hrdata_ff;
    nxt_dev_addr = dev_addr_ff;
    nxt_dev_wdata = dev_wdata_ff;
    nxt_dev_wr = 1'b0;
    nxt_dev_rd = 1'b0;
    nxt_poll_sel = poll_sel_ff;
    nxt_fin = fin_ff;
    nxt_shadow_a = shadow_a_ff;
    nxt_shadow_b = shadow_b_ff;
    nxt_shadow_c = shadow_c_ff;
    nxt_ready = ready_ff;
    nxt_clk_div = clk_div_ff;
    nxt_ref_bit = ref_bit_ff;
    nxt_ref_lp = ref_lp_ff;
    nxt_ref_cmd = ref_cmd_ff;
    nxt_stop = 1'b0;
    nxt_wait = 1'b0;
    nxt_fcmd_valid = 1'b0;
    nxt_fcmd_op = fcmd_op_ff;
    nxt_fcmd_addr = fcmd_addr_ff;
    trk_mark = 1'b0;
    trk_clear = 1'b0;

    // address phase: read data is prepared here so the data phase needs no wait state
    if (hsel && htrans[1] && hready) begin
      nxt_ap_wr = hwrite;
      nxt_ap_addr = haddr[7:0];
      if (haddr[7:0] == flash_host_pkg::OFS_CLK_DIV) begin
        rd_val = {29'h0, clk_div_ff};
      end else if (haddr[7:0] == flash_host_pkg::OFS_STATUS) begin
        rd_val[flash_host_pkg::ST_BUSY] = (state_ff != flash_host_pkg::st_idle);
        rd_val[flash_host_pkg::ST_READY] = ready_ff;
        rd_val[flash_host_pkg::ST_SUSPEND] = suspended;
        rd_val[flash_host_pkg::ST_LCR] = lcr_on;
        rd_val[flash_host_pkg::ST_REF_BIT] = ref_bit_ff;
        rd_val[flash_host_pkg::ST_REF_LP] = ref_lp_ff;
        rd_val[flash_host_pkg::ST_REF_CMD] = ref_cmd_ff;
      end else if (haddr[7:0] == flash_host_pkg::OFS_SHADOW) begin
        rd_val = {8'h00, shadow_c_ff, shadow_b_ff, shadow_a_ff};
      end
      if (!hwrite) begin
        nxt_hrdata = rd_val;
      end
    end

    // background poll of ready flag and of the register the device may change itself
    if (dev_rd_ff) begin
      if (dev_addr_ff == flash_host_pkg::DEV_STATE) begin
        nxt_ready = dev_rdata[flash_host_pkg::FLASH_READY_FLAG_BIT];
      end else begin
        nxt_shadow_c = dev_rdata;
      end
    end

    case (state_ff)
      flash_host_pkg::st_idle: begin
        nxt_dev_rd = 1'b1;
        nxt_dev_addr = poll_sel_ff ? flash_host_pkg::DEV_CTRL_C : flash_host_pkg::DEV_STATE;
        nxt_poll_sel = !poll_sel_ff;
      end
      flash_host_pkg::st_second: begin
        // final write lands in the very next cycle, no poll read in between
        nxt_dev_wr = 1'b1;
        nxt_dev_wdata = fin_ff;
        nxt_state = flash_host_pkg::st_idle;
      end
      default: begin
        nxt_state = flash_host_pkg::st_idle;
      end
    endcase

    // data phase of a write
    if (ap_wr_ff) begin
      if (ap_addr_ff == flash_host_pkg::OFS_BIT_CMD) begin
        if (bc_reg == flash_host_pkg::DEV_CTRL_A) begin
          cur = shadow_a_ff;
          set_guard = flash_host_pkg::SET_GUARD_A;
        end else if (bc_reg == flash_host_pkg::DEV_CTRL_B) begin
          cur = shadow_b_ff;
          set_guard = flash_host_pkg::SET_GUARD_B;
          clr_guard = flash_host_pkg::CLR_GUARD_B;
        end else begin
          cur = shadow_c_ff;
          set_guard = flash_host_pkg::SET_GUARD_C;
        end
        bmask = 8'h01 << bc_idx;
        fin = bc_val ? (cur | bmask) : (cur & ~bmask);
        unlock = (bc_val && ((set_guard & bmask) != 8'h00)) || (!bc_val && ((clr_guard & bmask) != 8'h00));
        lcr_bad = (bc_reg == flash_host_pkg::DEV_CTRL_C) && (bc_idx == flash_host_pkg::LOW_CURRENT_READ_ENABLE_BIT)
                  && bc_val && (clk_div_ff < flash_host_pkg::DIV_BY4 || clk_div_ff > flash_host_pkg::DIV_BY16);
        if (state_ff != flash_host_pkg::st_idle || bc_reg == flash_host_pkg::DEV_STATE || lcr_bad) begin
          nxt_ref_bit = 1'b1;
        end else begin
          nxt_dev_rd = 1'b0;
          nxt_dev_wr = 1'b1;
          nxt_dev_addr = bc_reg;
          nxt_dev_wdata = unlock ? (fin ^ bmask) : fin;
          nxt_fin = fin;
          nxt_state = unlock ? flash_host_pkg::st_second : flash_host_pkg::st_idle;
          if (bc_reg == flash_host_pkg::DEV_CTRL_A) begin
            nxt_shadow_a = fin;
          end else if (bc_reg == flash_host_pkg::DEV_CTRL_B) begin
            nxt_shadow_b = fin;
          end else begin
            nxt_shadow_c = fin;
          end
        end
      end else if (ap_addr_ff == flash_host_pkg::OFS_LP_CMD) begin
        if (hwdata[flash_host_pkg::LP_STOP_BIT] || hwdata[flash_host_pkg::LP_WAIT_BIT]) begin
          if (ready_ff && !suspended && !lcr_on) begin
            nxt_stop = hwdata[flash_host_pkg::LP_STOP_BIT];
            nxt_wait = hwdata[flash_host_pkg::LP_WAIT_BIT];
          end else begin
            nxt_ref_lp = 1'b1;
          end
        end
      end else if (ap_addr_ff == flash_host_pkg::OFS_FLASH_CMD) begin
        if ((fc_op == flash_host_pkg::OP_PROGRAM && trk_hit)
            || (fc_op == flash_host_pkg::OP_BLANK_CHECK && suspended)
            || (fc_op > flash_host_pkg::OP_ERASE)) begin
          nxt_ref_cmd = 1'b1;
        end else begin
          nxt_fcmd_valid = 1'b1;
          nxt_fcmd_op = fc_op;
          nxt_fcmd_addr = fc_addr;
          trk_mark = (fc_op == flash_host_pkg::OP_PROGRAM);
          trk_clear = (fc_op == flash_host_pkg::OP_ERASE);
        end
      end else if (ap_addr_ff == flash_host_pkg::OFS_CLK_DIV) begin
        // divide by 1 and divide by 2 are refused while low-current read is on
        if (hwdata[2:0] > flash_host_pkg::DIV_BY16 || (lcr_on && hwdata[2:0] < flash_host_pkg::DIV_BY4)) begin
          nxt_ref_bit = 1'b1;
        end else begin
          nxt_clk_div = hwdata[2:0];
        end
      end else if (ap_addr_ff == flash_host_pkg::OFS_STATUS) begin
        // write one to clear; no set can come from the same write
        if (hwdata[flash_host_pkg::ST_REF_BIT]) begin
          nxt_ref_bit = 1'b0;
        end
        if (hwdata[flash_host_pkg::ST_REF_LP]) begin
          nxt_ref_lp = 1'b0;
        end
        if (hwdata[flash_host_pkg::ST_REF_CMD]) begin
          nxt_ref_cmd = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= flash_host_pkg::st_idle;
      ap_wr_ff <= 1'b0;
      ap_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
      dev_addr_ff <= flash_host_pkg::DEV_STATE;
      dev_wdata_ff <= 8'h00;
      dev_wr_ff <= 1'b0;
      dev_rd_ff <= 1'b0;
      poll_sel_ff <= 1'b0;
      fin_ff <= 8'h00;
      shadow_a_ff <= flash_host_pkg::RST_SHADOW;
      shadow_b_ff <= flash_host_pkg::RST_SHADOW;
      shadow_c_ff <= flash_host_pkg::RST_SHADOW;
      ready_ff <= 1'b0;
      clk_div_ff <= flash_host_pkg::RST_CLK_DIV;
      ref_bit_ff <= 1'b0;
      ref_lp_ff <= 1'b0;
      ref_cmd_ff <= 1'b0;
      stop_ff <= 1'b0;
      wait_ff <= 1'b0;
      fcmd_valid_ff <= 1'b0;
      fcmd_op_ff <= 2'h0;
      fcmd_addr_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      ap_wr_ff <= nxt_ap_wr;
      ap_addr_ff <= nxt_ap_addr;
      hrdata_ff <= nxt_hrdata;
      dev_addr_ff <= nxt_dev_addr;
      dev_wdata_ff <= nxt_dev_wdata;
      dev_wr_ff <= nxt_dev_wr;
      dev_rd_ff <= nxt_dev_rd;
      poll_sel_ff <= nxt_poll_sel;
      fin_ff <= nxt_fin;
      shadow_a_ff <= nxt_shadow_a;
      shadow_b_ff <= nxt_shadow_b;
      shadow_c_ff <= nxt_shadow_c;
      ready_ff <= nxt_ready;
      clk_div_ff <= nxt_clk_div;
      ref_bit_ff <= nxt_ref_bit;
      ref_lp_ff <= nxt_ref_lp;
      ref_cmd_ff <= nxt_ref_cmd;
      stop_ff <= nxt_stop;
      wait_ff <= nxt_wait;
      fcmd_valid_ff <= nxt_fcmd_valid;
      fcmd_op_ff <= nxt_fcmd_op;
      fcmd_addr_ff <= nxt_fcmd_addr;
    end
  end

  // zero wait states and an okay response always; hsize is ignored, all accesses are words
  logic hready_ff, hresp_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0 & hsize[0];
    end
  end

  assign hreadyout = hready_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign dev_addr = dev_addr_ff;
  assign dev_wdata = dev_wdata_ff;
  assign dev_wr = dev_wr_ff;
  assign dev_rd = dev_rd_ff;
  assign cpu_div = clk_div_ff;
  assign stop_req = stop_ff;
  assign wait_req = wait_ff;
  assign fcmd_valid = fcmd_valid_ff;
  assign fcmd_op = fcmd_op_ff;
  assign fcmd_addr = fcmd_addr_ff;
endmodule : flash_ctrl_unlock_interlock

// ==== hdl/prog_tracker.sv ====
// remembers which flash addresses were programmed since the last erase
`timescale 1ns/1ps
module prog_tracker #(
  parameter int ADDR_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [ADDR_W-1:0] chk_addr,
  input wire logic mark,
  input wire logic clear_all,
  output logic hit
);
  localparam int DEPTH = 1 << ADDR_W;

  logic [DEPTH-1:0] done_ff;
  logic [DEPTH-1:0] nxt_done;

  assign hit = done_ff[chk_addr];

  always_comb begin
    nxt_done = done_ff;
    // erase wipes the whole map; a program marks one entry
    if (clear_all) begin
      nxt_done = '0;
    end else if (mark) begin
      nxt_done[chk_addr] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_ff <= '0;
    end else begin
      done_ff <= nxt_done;
    end
  end
endmodule : prog_tracker

// ==== include/flash_host_pkg.sv ====
// constants, field positions and types for the flash control host
package flash_host_pkg;
  // own register map, byte offsets on the ahb-lite slave
  localparam logic [7:0] OFS_BIT_CMD = 8'h00;
  localparam logic [7:0] OFS_LP_CMD = 8'h04;
  localparam logic [7:0] OFS_FLASH_CMD = 8'h08;
  localparam logic [7:0] OFS_CLK_DIV = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_SHADOW = 8'h14;

  // device register select on the device port
  localparam logic [1:0] DEV_CTRL_A = 2'h0;
  localparam logic [1:0] DEV_CTRL_B = 2'h1;
  localparam logic [1:0] DEV_CTRL_C = 2'h2;
  localparam logic [1:0] DEV_STATE = 2'h3;

  // bit positions inside the device registers
  localparam logic [2:0] REWRITE_MODE_ENABLE_BIT = 3'h1;
  localparam logic [2:0] REWRITE_MODE_SELECT_BIT = 3'h2;
  localparam logic [2:0] LOCK_BIT_DISABLE_BIT = 3'h3;
  localparam logic [2:0] BLOCK_LOCK_A_BIT = 3'h4;
  localparam logic [2:0] BLOCK_LOCK_B_BIT = 3'h5;
  localparam logic [2:0] BLOCK_LOCK_C_BIT = 3'h6;
  localparam logic [2:0] BLOCK_LOCK_D_BIT = 3'h7;
  localparam logic [2:0] ERASE_SUSPEND_ENABLE_BIT = 3'h0;
  localparam logic [2:0] ERASE_SUSPEND_REQUEST_BIT = 3'h1;
  localparam logic [2:0] IRQ_SUSPEND_ENABLE_BIT = 3'h2;
  localparam logic [2:0] LOW_CURRENT_READ_ENABLE_BIT = 3'h7;
  localparam logic [2:0] FLASH_READY_FLAG_BIT = 3'h7;

  // bits that need the opposite value written first when set to one
  localparam logic [7:0] SET_GUARD_A = (8'h01 << REWRITE_MODE_ENABLE_BIT) | (8'h01 << REWRITE_MODE_SELECT_BIT);
  localparam logic [7:0] SET_GUARD_B = 8'h01 << LOCK_BIT_DISABLE_BIT;
  localparam logic [7:0] SET_GUARD_C = (8'h01 << ERASE_SUSPEND_ENABLE_BIT) | (8'h01 << IRQ_SUSPEND_ENABLE_BIT)
                                      | (8'h01 << LOW_CURRENT_READ_ENABLE_BIT);
  // bits that need a one written first when cleared to zero
  localparam logic [7:0] CLR_GUARD_B = (8'h01 << BLOCK_LOCK_A_BIT) | (8'h01 << BLOCK_LOCK_B_BIT)
                                      | (8'h01 << BLOCK_LOCK_C_BIT) | (8'h01 << BLOCK_LOCK_D_BIT);

  // command field positions in hwdata
  localparam int BC_IDX_LSB = 0;
  localparam int BC_REG_LSB = 3;
  localparam int BC_VAL_BIT = 8;
  localparam int LP_STOP_BIT = 0;
  localparam int LP_WAIT_BIT = 1;
  localparam int FC_OP_LSB = 0;
  localparam int FC_ADDR_LSB = 8;

  // status register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_READY = 1;
  localparam int ST_SUSPEND = 2;
  localparam int ST_LCR = 3;
  localparam int ST_REF_BIT = 4;
  localparam int ST_REF_LP = 5;
  localparam int ST_REF_CMD = 6;

  // cpu clock divide codes
  localparam logic [2:0] DIV_BY1 = 3'h0;
  localparam logic [2:0] DIV_BY2 = 3'h1;
  localparam logic [2:0] DIV_BY4 = 3'h2;
  localparam logic [2:0] DIV_BY8 = 3'h3;
  localparam logic [2:0] DIV_BY16 = 3'h4;

  // flash command codes
  localparam logic [1:0] OP_PROGRAM = 2'h0;
  localparam logic [1:0] OP_BLANK_CHECK = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;

  // reset values
  localparam logic [2:0] RST_CLK_DIV = DIV_BY1;
  localparam logic [7:0] RST_SHADOW = 8'h00;

  typedef enum logic [0:0] {st_idle, st_second} seq_state_type;
endpackage : flash_host_pkg

// ==== tb/flash_dev_model.sv ====
// behavioural model of the flash control registers behind the device port
`timescale 1ns/1ps
module flash_dev_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  output logic [7:0] dev_rdata,
  input wire logic ready,
  input wire logic irq_ack,
  output logic low_current
);
  logic [7:0] ctrl_a_ff, ctrl_b_ff, ctrl_c_ff, prev_ff, last_ff, cur, setm, clrm, guard, taken;
  logic [1:0] paddr_ff;
  logic pwr_ff;
  always_comb begin
    case (dev_addr)
      2'h0: cur = ctrl_a_ff;
      2'h1: cur = ctrl_b_ff;
      2'h2: cur = ctrl_c_ff;
      default: cur = {ready, 7'h00};
    endcase
    setm = (dev_addr == 2'h0) ? flash_host_pkg::SET_GUARD_A : (dev_addr == 2'h1) ? flash_host_pkg::SET_GUARD_B
         : (dev_addr == 2'h2) ? flash_host_pkg::SET_GUARD_C : 8'h00;
    clrm = (dev_addr == 2'h1) ? flash_host_pkg::CLR_GUARD_B : 8'h00;
    guard = (dev_wdata & ~cur & setm) | (~dev_wdata & cur & clrm);
    // only a write in the cycle just before, same register, opposite value, opens the bit
    if (pwr_ff && paddr_ff == dev_addr) guard = guard & ~(prev_ff ^ dev_wdata);
    taken = (dev_wdata & ~guard) | (cur & guard);
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_a_ff <= 8'h00;
      ctrl_b_ff <= 8'h00;
      ctrl_c_ff <= 8'h00;
      pwr_ff <= 1'b0;
      last_ff <= 8'h00;
    end else begin
      pwr_ff <= dev_wr;
      prev_ff <= dev_wdata;
      paddr_ff <= dev_addr;
      if (dev_wr && dev_addr == 2'h0) ctrl_a_ff <= taken;
      if (dev_wr && dev_addr == 2'h1) ctrl_b_ff <= taken;
      // clearing the request bit by a write restarts the erase
      if (dev_wr && dev_addr == 2'h2) ctrl_c_ff <= taken;
      else if (irq_ack && ctrl_c_ff[0] && ctrl_c_ff[2]) ctrl_c_ff[1] <= 1'b1;
      if (dev_rd) last_ff <= cur;
    end
  end
  // an unselected data bus shows a changed value, never a stale one
  assign dev_rdata = dev_rd ? cur : ~last_ff;
  assign low_current = ctrl_c_ff[7];
endmodule : flash_dev_model

// ==== tb/flash_host_props.sv ====
// concurrent checks on the device port and command outputs of the flash control host
`timescale 1ns/1ps
module flash_host_props #(
  parameter int ADDR_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  input wire logic [7:0] dev_rdata,
  input wire logic [2:0] cpu_div,
  input wire logic stop_req,
  input wire logic wait_req,
  input wire logic fcmd_valid,
  input wire logic [1:0] fcmd_op,
  input wire logic [ADDR_W-1:0] fcmd_addr
);
  logic [7:0] wr_a_ff, wr_b_ff, wr_c_ff, poll_c_ff, last_w, set_m, clr_m, turned;
  logic ready_ff;
  logic [2**ADDR_W-1:0] prog_ff;
  logic lp, susp_w, lcr_w;
  assign lp = stop_req | wait_req;
  assign susp_w = poll_c_ff[1];
  assign lcr_w = poll_c_ff[7];
  // guarded bits that a write turns over, judged against the last byte written there
  always_comb begin
    case (dev_addr)
      2'h0: begin
        last_w = wr_a_ff;
        set_m = flash_host_pkg::SET_GUARD_A;
      end
      2'h1: begin
        last_w = wr_b_ff;
        set_m = flash_host_pkg::SET_GUARD_B;
      end
      default: begin
        last_w = wr_c_ff;
        set_m = flash_host_pkg::SET_GUARD_C;
      end
    endcase
    clr_m = (dev_addr == 2'h1) ? flash_host_pkg::CLR_GUARD_B : 8'h00;
    turned = (dev_wdata & ~last_w & set_m) | (~dev_wdata & last_w & clr_m);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_a_ff <= 8'h00;
      wr_b_ff <= 8'h00;
      wr_c_ff <= 8'h00;
      poll_c_ff <= 8'h00;
      ready_ff <= 1'b0;
      prog_ff <= '0;
    end else begin
      if (dev_wr && dev_addr == 2'h0) wr_a_ff <= dev_wdata;
      if (dev_wr && dev_addr == 2'h1) wr_b_ff <= dev_wdata;
      if (dev_wr && dev_addr == 2'h2) wr_c_ff <= dev_wdata;
      // the device may raise its suspend request itself, so the poll is tracked too
      if (dev_wr && dev_addr == 2'h2) poll_c_ff <= dev_wdata;
      else if (dev_rd && dev_addr == 2'h2) poll_c_ff <= dev_rdata;
      if (dev_rd && dev_addr == 2'h3) ready_ff <= dev_rdata[7];
      if (fcmd_valid && fcmd_op == flash_host_pkg::OP_PROGRAM) prog_ff[fcmd_addr] <= 1'b1;
      if (fcmd_valid && fcmd_op == flash_host_pkg::OP_ERASE) prog_ff <= '0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_guard_unlock: assert property (dev_wr && turned != 8'h00 |-> $past(dev_wr) && $past(dev_addr) == dev_addr)
    else $error("guarded bit changed without an opposite write just before");
  a_pair_one_bit: assert property (dev_wr && $past(dev_wr) && $past(dev_addr) == dev_addr
    |-> $countones(dev_wdata ^ $past(dev_wdata)) == 1) else $error("unlock pair bytes differ in other bits");
  a_pair_then_poll: assert property (dev_wr && $past(dev_wr) |=> !dev_wr && dev_rd)
    else $error("third write or no poll after unlock pair");
  a_lp_ready: assert property (lp |-> $past(ready_ff)) else $error("low power while flash busy");
  a_lp_suspend: assert property (lp |-> !$past(susp_w)) else $error("low power during suspend");
  a_lp_lowcur: assert property (lp |-> !$past(lcr_w)) else $error("low power with low current read on");
  a_lcr_div: assert property (dev_wr && dev_addr == 2'h2 && dev_wdata[7] |-> cpu_div inside {[3'h2:3'h4]})
    else $error("low current read set with bad divider");
  a_div_hold: assert property (lcr_w |-> cpu_div inside {[3'h2:3'h4]}) else $error("divider left range");
  a_blank_susp: assert property (fcmd_valid && fcmd_op == 2'h1 |-> !$past(susp_w))
    else $error("blank check during suspend");
  a_no_reprog: assert property (fcmd_valid && fcmd_op == 2'h0 |-> !prog_ff[fcmd_addr])
    else $error("address programmed twice");
  c_unlock: cover property (dev_wr ##1 dev_wr);
  c_stop: cover property (stop_req);
  c_program: cover property (fcmd_valid && fcmd_op == 2'h0);
endmodule : flash_host_props

bind flash_ctrl_unlock_interlock flash_host_props #(.ADDR_W(ADDR_W)) flash_host_props_inst (.hclk, .hresetn,
  .dev_addr, .dev_wdata, .dev_wr, .dev_rd, .dev_rdata, .cpu_div, .stop_req, .wait_req, .fcmd_valid, .fcmd_op,
  .fcmd_addr);

// ==== tb/tb_flash_ctrl_unlock_interlock.sv ====
// self-checking bench for the flash control host
`timescale 1ns/1ps
module tb_flash_ctrl_unlock_interlock;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic irq_ack = 1'b0;
  logic flash_ready = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, dev_wr, dev_rd, stop_req, wait_req, fcmd_valid, low_current;
  logic [1:0] dev_addr, fcmd_op;
  logic [7:0] dev_wdata, dev_rdata, fcmd_addr;
  logic [2:0] cpu_div;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int stops = 0, waits = 0, cmds = 0;
  always #5 hclk = ~hclk;
  flash_ctrl_unlock_interlock flash_ctrl_unlock_interlock_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .dev_addr, .dev_wdata, .dev_wr, .dev_rd,
    .dev_rdata, .cpu_div, .stop_req, .wait_req, .fcmd_valid, .fcmd_op, .fcmd_addr);
  flash_dev_model flash_dev_model_inst (.hclk, .hresetn, .dev_addr, .dev_wdata, .dev_wr, .dev_rd, .dev_rdata,
    .ready(flash_ready), .irq_ack, .low_current);
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  always @(posedge hclk) begin
    stops += (stop_req === 1'b1);
    waits += (wait_req === 1'b1);
    cmds += (fcmd_valid === 1'b1);
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one single transfer; the master waits on hready, never on a cycle count
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic rd_chk(input logic [7:0] a, input string what, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(what, rd, exp);
  endtask : rd_chk
  task automatic bit_cmd(input logic [1:0] r, input logic [2:0] i, input logic v);
    xfer(8'h00, 1'b1, {23'h0, v, 3'h0, r, i});
    repeat (4) @(posedge hclk);
  endtask : bit_cmd
  task automatic flash_cmd(input logic [1:0] op, input logic [7:0] a, input int exp_cmds);
    xfer(8'h08, 1'b1, {16'h0, a, 6'h0, op});
    repeat (4) @(posedge hclk);
    chk("command pulses", cmds, exp_cmds);
  endtask : flash_cmd
  task automatic t_reset;
    rd_chk(8'h14, "shadow", 32'h0);
    rd_chk(8'h0C, "divider", {29'h0, flash_host_pkg::RST_CLK_DIV});
    chk("bus response", {hreadyout, hresp}, 32'h2);
    xfer(8'h1C, 1'b1, 32'hFFFFFFFF);
    rd_chk(8'h1C, "unmapped", 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_unlock;
    logic [1:0] rs [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
    logic [2:0] bs [6] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h2, 3'h7};
    bit_cmd(2'h2, 3'h7, 1'b1);
    rd_chk(8'h10, "status refused bit", 32'h12);
    xfer(8'h10, 1'b1, 32'h70);
    xfer(8'h0C, 1'b1, {29'h0, flash_host_pkg::DIV_BY8});
    for (int k = 0; k < 6; k++) bit_cmd(rs[k], bs[k], 1'b1);
    chk("device regs", {flash_dev_model_inst.ctrl_c_ff, flash_dev_model_inst.ctrl_b_ff,
      flash_dev_model_inst.ctrl_a_ff}, 32'h850806);
    rd_chk(8'h14, "shadow", 32'h850806);
    chk("low current", low_current, 1'b1);
    xfer(8'h0C, 1'b1, {29'h0, flash_host_pkg::DIV_BY2});
    rd_chk(8'h10, "status divider refused", 32'h1A);
    chk("divider kept", cpu_div, flash_host_pkg::DIV_BY8);
    xfer(8'h10, 1'b1, 32'h70);
    $display("unlock test done");
  endtask : t_unlock
  task automatic t_locks;
    for (int i = 4; i < 8; i++) bit_cmd(2'h1, i[2:0], 1'b1);
    chk("locks set", flash_dev_model_inst.ctrl_b_ff, 8'hF8);
    for (int i = 4; i < 8; i++) bit_cmd(2'h1, i[2:0], 1'b0);
    chk("locks cleared", flash_dev_model_inst.ctrl_b_ff, 8'h08);
    $display("lock test done");
  endtask : t_locks
  task automatic t_lp;
    xfer(8'h04, 1'b1, 32'h1);
    repeat (4) @(posedge hclk);
    chk("stop with low current", stops, 0);
    bit_cmd(2'h2, 3'h7, 1'b0);
    flash_ready <= 1'b0;
    repeat (4) @(posedge hclk);
    xfer(8'h04, 1'b1, 32'h2);
    repeat (4) @(posedge hclk);
    rd_chk(8'h10, "status busy refusal", 32'h20);
    chk("wait while busy", waits, 0);
    flash_ready <= 1'b1;
    xfer(8'h10, 1'b1, 32'h70);
    repeat (4) @(posedge hclk);
    xfer(8'h04, 1'b1, 32'h1);
    xfer(8'h04, 1'b1, 32'h2);
    repeat (4) @(posedge hclk);
    chk("pulses", {stops[15:0], waits[15:0]}, 32'h00010001);
    $display("low power test done");
  endtask : t_lp
  task automatic t_susp;
    irq_ack <= 1'b1;
    @(posedge hclk);
    irq_ack <= 1'b0;
    repeat (4) @(posedge hclk);
    xfer(8'h04, 1'b1, 32'h1);
    rd_chk(8'h10, "status suspended", 32'h26);
    chk("stop in suspend", stops, 1);
    flash_cmd(2'h1, 8'h00, 0);
    bit_cmd(2'h2, 3'h1, 1'b0);
    flash_cmd(2'h1, 8'h00, 1);
    xfer(8'h10, 1'b1, 32'h70);
    $display("suspend test done");
  endtask : t_susp
  task automatic t_prog;
    flash_cmd(2'h0, 8'h05, 2);
    chk("program command", {fcmd_op, fcmd_addr}, {2'h0, 8'h05});
    flash_cmd(2'h0, 8'h05, 2);
    flash_cmd(2'h3, 8'h05, 2);
    rd_chk(8'h10, "status command refused", 32'h42);
    flash_cmd(2'h2, 8'h05, 3);
    flash_cmd(2'h0, 8'h05, 4);
    $display("program test done");
  endtask : t_prog
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_unlock();
    t_locks();
    t_lp();
    t_susp();
    t_prog();
    stop_test();
  end
endmodule : tb_flash_ctrl_unlock_interlock
